// [debounce_filter.sv]
// Steady state filter for one raw detector output.
// Assumes raw is synchronous to hclk and tick pulses once per step.
module debounce_filter #(
  parameter int W = line_feed_pkg::DB_W
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         tick,
  input  wire logic         raw,
  input  wire logic [W-1:0] limit,
  output logic              filtered
);
  logic         raw_q_ff;
  logic         filt_ff;
  logic [W-1:0] cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_q_ff <= 1'b0;
    end else begin
      raw_q_ff <= raw;
    end
  end

  // Any change of the raw level starts the interval again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end else if (raw != raw_q_ff || raw_q_ff == filt_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff >= limit) begin
      filt_ff <= raw_q_ff;
      cnt_ff  <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  assign filtered = filt_ff;

endmodule : debounce_filter

// [debounce_tick.sv]
// Free running divider giving one pulse per debounce step.
// Assumes a single clock; CYCLES may be shortened for simulation.
module debounce_tick #(
  parameter int CYCLES = line_feed_pkg::TICK_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  assign tick = (cnt_ff == LAST);

endmodule : debounce_tick

// [line_feed_config_regs.sv]
// Line feed configuration bank with its debounce filters, on AHB-Lite.
// Assumes one master, word transfers only, raw detector levels synchronous to hclk.
// Overview of operation
// - The loop closure debounce field holds 7 bits of 1.25 ms steps and resets to ten steps.
// - The ring trip debounce field holds 7 bits of 1.25 ms steps and resets to ten steps.
// - The 3-bit current limit code picks 20 mA to 41 mA in 3 mA steps.
// - Bit 6 of the on-hook register sets polarity, zero positive and one negative.
// - The 6-bit on-hook magnitude spans 0 V to 94.5 V in 1.5 V steps and resets to 48 V.
// - The common mode level drives tip in forward states and ring in reverse states.
// - The 6-bit common mode level spans 0 V to -94.5 V in 1.5 V steps and resets to -3 V.
// - The 6-bit high battery level spans 0 V to -94.5 V and resets to -75 V.
// - The 6-bit low battery level spans 0 V to -94.5 V and resets to -24 V.
// - The unfiltered detector level is visible and the filtered flags move only after debounce.
//
// Register access over AHB-Lite was left to the implementer.
module line_feed_config_regs #(
  parameter int ADDR_W      = 12,
  parameter int TICK_CYCLES = line_feed_pkg::TICK_CYCLES
) (
  input  wire logic                                hclk,
  input  wire logic                                hresetn,
  input  wire logic                                hsel,
  input  wire logic [ADDR_W-1:0]                   haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic                                     hreadyout,
  output logic                                     hresp,
  output logic [31:0]                              hrdata,
  input  wire logic                                closure_raw,
  input  wire logic                                trip_raw,
  output logic [line_feed_pkg::DB_W-1:0]           closure_debounce_count,
  output logic [line_feed_pkg::DB_W-1:0]           trip_debounce_count,
  output logic [line_feed_pkg::CUR_W-1:0]          current_limit_code,
  output logic                                     on_hook_polarity,
  output logic [line_feed_pkg::LEVEL_W-1:0]        on_hook_magnitude,
  output logic [line_feed_pkg::LEVEL_W-1:0]        common_mode_level,
  output logic [line_feed_pkg::LEVEL_W-1:0]        high_battery_level,
  output logic [line_feed_pkg::LEVEL_W-1:0]        low_battery_level,
  output logic                                     unfiltered_detect_out,
  output logic                                     filtered_closure_flag,
  output logic                                     filtered_trip_flag
);

  logic                                 accept;
  logic                                 wr_pend_ff;
  logic                                 rd_pend_ff;
  logic [9:0]                           idx_ff;
  logic [31:0]                          hrdata_ff;
  logic [31:0]                          nxt_rdata;
  logic [line_feed_pkg::DB_W-1:0]       closure_db_ff;
  logic [line_feed_pkg::DB_W-1:0]       trip_db_ff;
  logic [line_feed_pkg::CUR_W-1:0]      cur_limit_ff;
  logic                                 polarity_ff;
  logic [line_feed_pkg::LEVEL_W-1:0]    magnitude_ff;
  logic [line_feed_pkg::LEVEL_W-1:0]    common_mode_ff;
  logic [line_feed_pkg::LEVEL_W-1:0]    high_bat_ff;
  logic [line_feed_pkg::LEVEL_W-1:0]    low_bat_ff;
  logic                                 tick;
  logic                                 closure_filt;
  logic                                 trip_filt;

  // Bus address phase
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      idx_ff     <= '0;
    end else begin
      wr_pend_ff <= accept && hwrite;
      rd_pend_ff <= accept && !hwrite;
      if (accept) begin
        idx_ff <= haddr[11:2];
      end
    end
  end

  // One wait state on reads keeps hrdata straight from a flip-flop
  assign hreadyout = !rd_pend_ff;
  assign hresp     = 1'b0;

  // Write data phase; only the field bits are stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      closure_db_ff <= line_feed_pkg::RST_CLOSURE_DB;
      trip_db_ff    <= line_feed_pkg::RST_TRIP_DB;
    end else if (wr_pend_ff) begin
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_CLOSURE_DB)) begin
        closure_db_ff <= hwdata[line_feed_pkg::DB_W-1:0];
      end
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_TRIP_DB)) begin
        trip_db_ff <= hwdata[line_feed_pkg::DB_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_limit_ff <= line_feed_pkg::RST_CUR_LIMIT;
      polarity_ff  <= line_feed_pkg::RST_POLARITY;
      magnitude_ff <= line_feed_pkg::RST_MAGNITUDE;
    end else if (wr_pend_ff) begin
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_CUR_LIMIT)) begin
        cur_limit_ff <= hwdata[line_feed_pkg::CUR_W-1:0];
      end
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_ON_HOOK)) begin
        polarity_ff  <= hwdata[line_feed_pkg::POLARITY_BIT];
        magnitude_ff <= hwdata[line_feed_pkg::LEVEL_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      common_mode_ff <= line_feed_pkg::RST_COMMON_MODE;
      high_bat_ff    <= line_feed_pkg::RST_HIGH_BAT;
      low_bat_ff     <= line_feed_pkg::RST_LOW_BAT;
    end else if (wr_pend_ff) begin
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_COMMON_MODE)) begin
        common_mode_ff <= hwdata[line_feed_pkg::LEVEL_W-1:0];
      end
      // Ordering of the two battery levels is left to software
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_HIGH_BAT)) begin
        high_bat_ff <= hwdata[line_feed_pkg::LEVEL_W-1:0];
      end
      if (line_feed_pkg::idx_hit(idx_ff, line_feed_pkg::IDX_LOW_BAT)) begin
        low_bat_ff <= hwdata[line_feed_pkg::LEVEL_W-1:0];
      end
    end
  end

  // Read mux, reserved and unmapped bits read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    case (idx_ff)
      line_feed_pkg::IDX_DETECT_STATUS: begin
        nxt_rdata[line_feed_pkg::STAT_CLOSURE_BIT] = closure_filt;
        nxt_rdata[line_feed_pkg::STAT_TRIP_BIT]    = trip_filt;
        nxt_rdata[line_feed_pkg::STAT_RAW_BIT]     = unfiltered_detect_out;
      end
      line_feed_pkg::IDX_CLOSURE_DB: begin
        nxt_rdata[line_feed_pkg::DB_W-1:0] = closure_db_ff;
      end
      line_feed_pkg::IDX_TRIP_DB: begin
        nxt_rdata[line_feed_pkg::DB_W-1:0] = trip_db_ff;
      end
      line_feed_pkg::IDX_CUR_LIMIT: begin
        nxt_rdata[line_feed_pkg::CUR_W-1:0] = cur_limit_ff;
      end
      line_feed_pkg::IDX_ON_HOOK: begin
        nxt_rdata[line_feed_pkg::POLARITY_BIT]  = polarity_ff;
        nxt_rdata[line_feed_pkg::LEVEL_W-1:0]   = magnitude_ff;
      end
      line_feed_pkg::IDX_COMMON_MODE: begin
        nxt_rdata[line_feed_pkg::LEVEL_W-1:0] = common_mode_ff;
      end
      line_feed_pkg::IDX_HIGH_BAT: begin
        nxt_rdata[line_feed_pkg::LEVEL_W-1:0] = high_bat_ff;
      end
      line_feed_pkg::IDX_LOW_BAT: begin
        nxt_rdata[line_feed_pkg::LEVEL_W-1:0] = low_bat_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  assign hrdata = hrdata_ff;

  // Detector filtering
  debounce_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  debounce_filter #(
    .W (line_feed_pkg::DB_W)
  ) u_closure (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick     (tick),
    .raw      (closure_raw),
    .limit    (closure_db_ff),
    .filtered (closure_filt)
  );

  debounce_filter #(
    .W (line_feed_pkg::DB_W)
  ) u_trip (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .tick     (tick),
    .raw      (trip_raw),
    .limit    (trip_db_ff),
    .filtered (trip_filt)
  );

  // Low while either threshold is exceeded
  assign unfiltered_detect_out = !(closure_raw || trip_raw);
  assign filtered_closure_flag = closure_filt;
  assign filtered_trip_flag    = trip_filt;

  assign closure_debounce_count = closure_db_ff;
  assign trip_debounce_count    = trip_db_ff;
  assign current_limit_code     = cur_limit_ff;
  assign on_hook_polarity       = polarity_ff;
  assign on_hook_magnitude      = magnitude_ff;
  // Tip or ring selection by feed direction happens in the analog feed
  assign common_mode_level      = common_mode_ff;
  assign high_battery_level     = high_bat_ff;
  assign low_battery_level      = low_bat_ff;

  // Checks
  closure_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> closure_debounce_count == 7'h0A)
    else $error("closure debounce reset value wrong");

  closure_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h045 |=> closure_debounce_count == $past(hwdata[6:0]))
    else $error("closure debounce write lost");

  trip_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h046 |=> trip_debounce_count == $past(hwdata[6:0]))
    else $error("trip debounce write lost");

  limit_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_ff && idx_ff == 10'h047 |=> hreadyout && hrdata == {29'h0, current_limit_code})
    else $error("current limit read wrong");

  limit_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h047 |=> current_limit_code == $past(hwdata[2:0]))
    else $error("current limit write lost");

  polarity_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h048 |=> on_hook_polarity == $past(hwdata[6]) &&
    on_hook_magnitude == $past(hwdata[5:0]))
    else $error("on-hook write wrong");

  magnitude_reset_a: assert property (@(posedge hclk) $rose(hresetn) |->
    on_hook_magnitude == 6'h20 && !on_hook_polarity)
    else $error("on-hook reset value wrong");

  common_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend_ff && idx_ff == 10'h049) |=> $stable(common_mode_level))
    else $error("common mode changed without a write");

  common_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> common_mode_level == 6'h02)
    else $error("common mode reset value wrong");

  battery_reset_a: assert property (@(posedge hclk) $rose(hresetn) |->
    high_battery_level == 6'h32 && low_battery_level == 6'h10)
    else $error("battery reset values wrong");

  high_bat_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h04A |=> high_battery_level == $past(hwdata[5:0]) &&
    $stable(low_battery_level))
    else $error("high battery write wrong");

  low_bat_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_ff && idx_ff == 10'h04B |=> low_battery_level == $past(hwdata[5:0]) &&
    $stable(high_battery_level))
    else $error("low battery write wrong");

  filter_steady_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(filtered_closure_flag) |-> $past(closure_raw, 2) == filtered_closure_flag &&
    $past(closure_raw) == filtered_closure_flag)
    else $error("closure flag moved without a steady raw level");

  trip_steady_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(filtered_trip_flag) |-> $past(trip_raw, 2) == filtered_trip_flag &&
    $past(trip_raw) == filtered_trip_flag)
    else $error("trip flag moved without a steady raw level");

  status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_ff && idx_ff == 10'h044 |=> hrdata[31:3] == 29'h0 &&
    hrdata[1:0] == $past({trip_filt, closure_filt}))
    else $error("status read wrong");

  // Holes in the map must never leak stale read data
  unmapped_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend_ff && idx_ff > 10'h04B |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  trip_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trip_raw != $past(trip_raw) |=> $stable(filtered_trip_flag))
    else $error("trip flag moved right after a raw change");

  closure_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    closure_raw != $past(closure_raw) |=> $stable(filtered_closure_flag))
    else $error("closure flag moved right after a raw change");

endmodule : line_feed_config_regs

// [line_feed_config_regs_tb_top.sv]
// Self-checking bench for the line feed configuration bank.
// Assumes the design files and line_feed_pkg are compiled first; assertions live in the design, readback and output checks in the bench.
module line_feed_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK  = 4;
  localparam int LIMIT = 20000;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        closure_raw;
  logic        trip_raw;
  logic [6:0]  closure_debounce_count;
  logic [6:0]  trip_debounce_count;
  logic [2:0]  current_limit_code;
  logic        on_hook_polarity;
  logic [5:0]  on_hook_magnitude;
  logic [5:0]  common_mode_level;
  logic [5:0]  high_battery_level;
  logic [5:0]  low_battery_level;
  logic        unfiltered_detect_out;
  logic        filtered_closure_flag;
  logic        filtered_trip_flag;
  int          mismatches;
  int          checked;
  int          cycles;
  logic [31:0] rd;

  // Register table in index order: reset values and writable masks
  logic [9:0]  idx_tab [7] = '{line_feed_pkg::IDX_CLOSURE_DB, line_feed_pkg::IDX_TRIP_DB,
                               line_feed_pkg::IDX_CUR_LIMIT, line_feed_pkg::IDX_ON_HOOK,
                               line_feed_pkg::IDX_COMMON_MODE, line_feed_pkg::IDX_HIGH_BAT,
                               line_feed_pkg::IDX_LOW_BAT};
  logic [31:0] rst_tab [7] = '{32'h0A, 32'h0A, 32'h0, 32'h20, 32'h02, 32'h32, 32'h10};
  logic [31:0] msk_tab [7] = '{32'h7F, 32'h7F, 32'h07, 32'h7F, 32'h3F, 32'h3F, 32'h3F};

  // Short tick keeps debounce runs to a few dozen cycles
  line_feed_config_regs #(.TICK_CYCLES(TICK)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .closure_raw(closure_raw), .trip_raw(trip_raw),
    .closure_debounce_count(closure_debounce_count), .trip_debounce_count(trip_debounce_count),
    .current_limit_code(current_limit_code), .on_hook_polarity(on_hook_polarity),
    .on_hook_magnitude(on_hook_magnitude), .common_mode_level(common_mode_level),
    .high_battery_level(high_battery_level), .low_battery_level(low_battery_level),
    .unfiltered_detect_out(unfiltered_detect_out),
    .filtered_closure_flag(filtered_closure_flag), .filtered_trip_flag(filtered_trip_flag));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] field_out(input int i);
    case (i)
      0: field_out = {25'h0, closure_debounce_count};
      1: field_out = {25'h0, trip_debounce_count};
      2: field_out = {29'h0, current_limit_code};
      3: field_out = {25'h0, on_hook_polarity, on_hook_magnitude};
      4: field_out = {26'h0, common_mode_level};
      5: field_out = {26'h0, high_battery_level};
      6: field_out = {26'h0, low_battery_level};
      default: field_out = 32'h0;
    endcase
  endfunction : field_out

  // One single transfer; waits on hready, never on a fixed count
  task automatic bus_xfer(input logic [9:0] idx, input logic w, input logic [31:0] wd,
                          output logic [31:0] rdat);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    chk({31'h0, hresp}, 32'h0, "response not OKAY");
  endtask : bus_xfer

  task automatic check_resets();
    for (int i = 0; i < 7; i++) begin
      bus_xfer(idx_tab[i], 1'b0, 32'h0, rd);
      chk(rd, rst_tab[i], "reset readback");
      chk(field_out(i), rst_tab[i], "reset field");
    end
    chk({30'h0, filtered_trip_flag, filtered_closure_flag}, 32'h0, "flags after reset");
  endtask : check_resets

  task automatic reserved_bits();
    for (int i = 0; i < 7; i++) begin
      bus_xfer(idx_tab[i], 1'b1, 32'hFFFFFFFF, rd);
      @(negedge hclk);
      chk(field_out(i), msk_tab[i], "field after all ones");
      bus_xfer(idx_tab[i], 1'b0, 32'h0, rd);
      chk(rd, msk_tab[i], "reserved bits read");
    end
    // Low before high; only upper bits are written, so every field, both batteries too, ends at zero
    for (int i = 6; i >= 0; i--) begin
      bus_xfer(idx_tab[i], 1'b1, 32'hFFFFFF80, rd);
      bus_xfer(idx_tab[i], 1'b0, 32'h0, rd);
      chk(rd, 32'h0, "upper bits only written");
    end
    bus_xfer(10'h04C, 1'b1, 32'hFFFFFFFF, rd);
    bus_xfer(10'h04C, 1'b0, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
  endtask : reserved_bits

  task automatic codes_and_polarity();
    for (int c = 0; c < 8; c++) begin
      bus_xfer(line_feed_pkg::IDX_CUR_LIMIT, 1'b1, 32'(c), rd);
      @(negedge hclk);
      chk({29'h0, current_limit_code}, 32'(c), "current limit code");
    end
    bus_xfer(line_feed_pkg::IDX_ON_HOOK, 1'b1, 32'h40, rd);
    @(negedge hclk);
    chk({25'h0, on_hook_polarity, on_hook_magnitude}, 32'h40, "negative polarity");
    bus_xfer(line_feed_pkg::IDX_ON_HOOK, 1'b1, 32'h3F, rd);
    @(negedge hclk);
    chk({25'h0, on_hook_polarity, on_hook_magnitude}, 32'h3F, "positive full scale");
    bus_xfer(line_feed_pkg::IDX_COMMON_MODE, 1'b1, 32'h15, rd);
    @(negedge hclk);
    chk({26'h0, common_mode_level}, 32'h15, "common mode level");
    // Rails matched to fixed supplies; high first so it never sits below low
    bus_xfer(line_feed_pkg::IDX_HIGH_BAT, 1'b1, 32'h30, rd);
    bus_xfer(line_feed_pkg::IDX_LOW_BAT, 1'b1, 32'h14, rd);
    @(negedge hclk);
    chk({20'h0, high_battery_level, low_battery_level}, 32'h00000C14, "battery rails");
    bus_xfer(line_feed_pkg::IDX_HIGH_BAT, 1'b0, 32'h0, rd);
    chk(rd, 32'h30, "high rail readback");
  endtask : codes_and_polarity

  // Counts edges until the flag reaches v and checks the window
  task automatic flag_time(input bit trip, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while ((trip ? filtered_trip_flag : filtered_closure_flag) !== v && n < hi + 5) begin
      @(posedge hclk);
      n++;
    end
    checked++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("BAD %0t flag took %0d cycles, window %0d to %0d", $time, n, lo, hi);
    end
  endtask : flag_time

  task automatic debounce_paths();
    bus_xfer(line_feed_pkg::IDX_CLOSURE_DB, 1'b1, 32'h3, rd);
    @(posedge hclk);
    closure_raw <= 1'b1;
    @(negedge hclk);
    chk({31'h0, unfiltered_detect_out}, 32'h0, "unfiltered output");
    repeat (6) @(posedge hclk);
    closure_raw <= 1'b0;
    repeat (30) @(posedge hclk);
    chk({31'h0, filtered_closure_flag}, 32'h0, "short pulse passed");
    closure_raw <= 1'b1;
    repeat (8) @(posedge hclk);
    closure_raw <= 1'b0;
    @(posedge hclk);
    closure_raw <= 1'b1;
    flag_time(1'b0, 1'b1, 3 * TICK, 4 * TICK + 3);
    bus_xfer(line_feed_pkg::IDX_DETECT_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h1, "status with closure");
    closure_raw <= 1'b0;
    flag_time(1'b0, 1'b0, 3 * TICK, 4 * TICK + 3);
    bus_xfer(line_feed_pkg::IDX_TRIP_DB, 1'b1, 32'h0, rd);
    trip_raw <= 1'b1;
    flag_time(1'b1, 1'b1, 0, 3);
    bus_xfer(line_feed_pkg::IDX_DETECT_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h2, "status with trip");
    trip_raw <= 1'b0;
    flag_time(1'b1, 1'b0, 0, 3);
    bus_xfer(line_feed_pkg::IDX_DETECT_STATUS, 1'b0, 32'h0, rd);
    chk(rd, 32'h4, "status idle");
  endtask : debounce_paths

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard well above the few hundred cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("BAD %0t run timed out", $time);
      tally_and_finish();
    end
  end

  initial begin
    mismatches  = 0;
    checked     = 0;
    cycles      = 0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 12'h000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    closure_raw = 1'b0;
    trip_raw    = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check_resets();
    reserved_bits();
    codes_and_polarity();
    debounce_paths();
    // Second reset mid-run must bring every field back
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check_resets();
    tally_and_finish();
  end

endmodule : line_feed_config_regs_tb_top

// [line_feed_pkg.sv]
// Constants shared by the line feed configuration bank and its helpers.
// Assumes a 100 MHz hclk; indices are word indices on the register bus.
package line_feed_pkg;

  // Register word indices, byte address is four times the index
  localparam logic [9:0] IDX_DETECT_STATUS = 10'h044;
  localparam logic [9:0] IDX_CLOSURE_DB    = 10'h045;
  localparam logic [9:0] IDX_TRIP_DB       = 10'h046;
  localparam logic [9:0] IDX_CUR_LIMIT     = 10'h047;
  localparam logic [9:0] IDX_ON_HOOK       = 10'h048;
  localparam logic [9:0] IDX_COMMON_MODE   = 10'h049;
  localparam logic [9:0] IDX_HIGH_BAT      = 10'h04A;
  localparam logic [9:0] IDX_LOW_BAT       = 10'h04B;

  // Field widths and positions
  localparam int DB_W        = 7;
  localparam int CUR_W       = 3;
  localparam int LEVEL_W     = 6;
  localparam int POLARITY_BIT = 6;
  localparam int STAT_CLOSURE_BIT = 0;
  localparam int STAT_TRIP_BIT    = 1;
  localparam int STAT_RAW_BIT     = 2;

  // Values after reset
  localparam logic [DB_W-1:0]    RST_CLOSURE_DB  = 7'h0A;
  localparam logic [DB_W-1:0]    RST_TRIP_DB     = 7'h0A;
  localparam logic [CUR_W-1:0]   RST_CUR_LIMIT   = 3'h0;
  localparam logic               RST_POLARITY    = 1'b0;
  localparam logic [LEVEL_W-1:0] RST_MAGNITUDE   = 6'h20;
  localparam logic [LEVEL_W-1:0] RST_COMMON_MODE = 6'h02;
  localparam logic [LEVEL_W-1:0] RST_HIGH_BAT    = 6'h32;
  localparam logic [LEVEL_W-1:0] RST_LOW_BAT     = 6'h10;

  // Debounce tick timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_US  = 1250;
  localparam int TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  function automatic logic idx_hit(input logic [9:0] idx, input logic [9:0] reg_idx);
    idx_hit = (idx == reg_idx);
  endfunction : idx_hit

endpackage : line_feed_pkg
